// File: core/sbl_top.sv
/*
  serial boot loader: loads the kernel over the serial link, as master or
  slave. assumes a memory port that takes a word per clock, slow link clock.
*/
`default_nettype none
module sbl_top #(
  parameter logic [31:0] VT_BASE = sbl_pkg::VT_BASE_DEF,
  parameter logic [31:0] BOOT_COUNT = sbl_pkg::CNT_RESET
) (
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic I_CORE_RELEASE,
  input wire logic I_BOOT_MASTER,
  input wire logic I_BOOT_SERIAL_CLOCK,
  input wire logic I_SLAVE_SELECT_INPUT_N,
  input wire logic I_SERIAL_DATA_IN,
  output logic O_BOOT_SERIAL_CLOCK,
  output logic O_BOOT_SERIAL_CLOCK_OE,
  output logic O_SERIAL_DATA_OUT,
  output logic O_SERIAL_DATA_OUT_OE,
  output logic O_BOOT_MEMORY_SELECT_LINE_N,
  output logic O_MEM_WE,
  output logic [31:0] O_MEM_ADDR,
  output logic [31:0] O_MEM_WDATA,
  output logic O_RX_DONE_IRQ,
  output logic O_BOOT_DONE,
  output logic O_BOOT_ABORT
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    sbl_pkg::sbl_state_t st;
    logic [31:0] ctl, dmac, idx, modi, cnt, baud, flg, div;
    logic [4:0] bitn;
    logic armed, sck, sck_d, sck_oe, dout, dout_oe, sel_n;
    logic pk_vld, pk_bit, pk_clr, we;
    logic [31:0] addr, wdata;
    logic irq, done, abort;
  } sbl_core_t;
  // count preset to the words of one load
  localparam sbl_core_t RST_VAL = '{
    st: sbl_pkg::ST_WAIT,
    ctl: sbl_pkg::CTL_RESET,
    dmac: sbl_pkg::DMAC_RESET,
    idx: VT_BASE,
    modi: sbl_pkg::MOD_RESET,
    cnt: BOOT_COUNT,
    baud: sbl_pkg::BAUD_RESET,
    flg: sbl_pkg::FLG_RESET,
    sck: 1'b1,
    sel_n: 1'b1,
    default: '0
  };
  sbl_core_t r;
  sbl_core_t n;
  logic [31:0] half;
  logic run, fall, rise;
  logic s_rel, s_strap, s_sck, s_ss_n, s_din;
  logic [4:0] sync_q;
  sbl_shift_if lnk ();
  if (BOOT_COUNT == '0) begin : g_chk
    $error("sbl_top: boot count must not be zero");
  end

  // ----------------------------------------------------------------------
  // pin synchronisers and packer
  // ----------------------------------------------------------------------
  sbl_sync #(.W(5)) u_sync (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .i_d({I_CORE_RELEASE, I_BOOT_MASTER, I_BOOT_SERIAL_CLOCK,
          I_SLAVE_SELECT_INPUT_N, I_SERIAL_DATA_IN}),
    .o_q(sync_q)
  );
  assign {s_rel, s_strap, s_sck, s_ss_n, s_din} = sync_q;
  sbl_pack u_pack (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .lnk(lnk.packer)
  );
  assign lnk.bit_vld = r.pk_vld;
  assign lnk.bit_val = r.pk_bit;
  assign lnk.clr = r.pk_clr;
  // decides whether the data output pin is driven for a given control
  function automatic logic drives_data(input logic [31:0] c);
    drives_data = c[sbl_pkg::CTL_PORT_EN] &
                  (c[sbl_pkg::CTL_MASTER] | ~c[sbl_pkg::CTL_DOUT_DIS]);
  endfunction : drives_data
  // clock half period is half the baud divisor
  assign half = r.baud >> 1;
  assign run = r.sck_oe && (r.st inside {sbl_pkg::ST_M_HEAD,
               sbl_pkg::ST_M_CHK, sbl_pkg::ST_M_VERIFY, sbl_pkg::ST_M_XFER});
  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    fall = 1'b0;
    rise = 1'b0;
    n.we = 1'b0;
    n.irq = 1'b0;
    n.pk_vld = 1'b0;
    n.pk_clr = 1'b0;
    n.sck_d = s_sck;
    if (run) begin
      if (r.div == half - sbl_pkg::CNT_ONE) begin
        n.div = '0;
        n.sck = ~r.sck;
        fall = r.sck;
        rise = ~r.sck;
      end else begin
        n.div = r.div + sbl_pkg::CNT_ONE;
      end
    end
    unique case (r.st)
      sbl_pkg::ST_WAIT: begin
        // nothing starts until the core reset is released
        if (s_rel) begin
          if (s_strap) begin
            n.ctl = sbl_pkg::CTL_MASTER_BOOT;
            n.sck_oe = 1'b1;
            n.dout_oe = drives_data(sbl_pkg::CTL_MASTER_BOOT);
            n.sck = sbl_pkg::CTL_MASTER_BOOT[sbl_pkg::CTL_CPOL];
            n.st = sbl_pkg::ST_M_SEL;
          end else begin
            n.ctl = sbl_pkg::CTL_SLAVE_BOOT;
            n.dout_oe = drives_data(sbl_pkg::CTL_SLAVE_BOOT);
            n.st = sbl_pkg::ST_S_ARM;
          end
        end
      end
      sbl_pkg::ST_M_SEL: begin
        // select goes low before the first clock edge
        n.sel_n = ~r.flg[sbl_pkg::FLG_SEL0];
        n.div = '0;
        n.bitn = '0;
        n.st = sbl_pkg::ST_M_HEAD;
      end
      sbl_pkg::ST_M_HEAD: begin
        // header driven on falling edge, lsb of the stored value first
        if (fall) begin
          n.dout = sbl_pkg::READ_HEADER[r.bitn];
        end
        if (rise) begin
          n.bitn = r.bitn + 5'h1;
          if (r.bitn == sbl_pkg::HDR_LAST) begin
            n.bitn = '0;
            n.st = sbl_pkg::ST_M_CHK;
          end
        end
      end
      sbl_pkg::ST_M_CHK: begin
        if (fall) begin
          n.dout = ~r.ctl[sbl_pkg::CTL_SEND_ZERO] & r.dout;
        end
        // data sampled on the rising edge
        if (rise) begin
          n.pk_vld = 1'b1;
          n.pk_bit = s_din;
          n.bitn = r.bitn + 5'h1;
          if (r.bitn == sbl_pkg::CHK_LAST) begin
            n.st = sbl_pkg::ST_M_VERIFY;
          end
        end
      end
      sbl_pkg::ST_M_VERIFY: begin
        // wait one cycle so the last check bit has reached the packer
        if (!r.pk_vld) begin
          // check byte decides between load and abort
          if (lnk.shift[31:24] == sbl_pkg::CHECK_BYTE) begin
            n.pk_clr = 1'b1;
            n.st = sbl_pkg::ST_M_XFER;
          end else begin
            n.sel_n = 1'b1;
            n.sck = 1'b1;
            n.abort = 1'b1;
            n.st = sbl_pkg::ST_ABORT;
          end
        end
      end
      sbl_pkg::ST_M_XFER: begin
        if (fall) begin
          n.dout = ~r.ctl[sbl_pkg::CTL_SEND_ZERO] & r.dout;
        end
        if (rise) begin
          n.pk_vld = 1'b1;
          n.pk_bit = s_din;
        end
      end
      sbl_pkg::ST_S_ARM: begin
        // select must be seen high before its fall counts as a start
        if (s_ss_n) begin
          n.armed = 1'b1;
        end else if (r.armed) begin
          // host select low after arming starts the slave load; the clock plays no part
          n.st = sbl_pkg::ST_S_RUN;
        end
      end
      sbl_pkg::ST_S_RUN: begin
        // slave samples on the synchronised rising edge
        if (s_sck && !r.sck_d && !s_ss_n) begin
          n.pk_vld = 1'b1;
          n.pk_bit = s_din;
        end
      end
      sbl_pkg::ST_DONE, sbl_pkg::ST_ABORT: begin
        n.sel_n = 1'b1;
      end
      default: begin
        n.abort = 1'b1;
        n.st = sbl_pkg::ST_ABORT;
      end
    endcase
    // packer never restarts between words, so the stream must be gapless
    if (lnk.word_vld && r.cnt != '0 && r.dmac[sbl_pkg::DMAC_EN] &&
        r.ctl[sbl_pkg::CTL_RX_DMA] && r.ctl[sbl_pkg::CTL_PORT_EN]) begin
      // consecutive words go to consecutive locations
      n.we = 1'b1;
      n.addr = r.idx;
      n.wdata = lnk.word;
      n.idx = r.idx + r.modi;
      n.cnt = r.cnt - sbl_pkg::CNT_ONE;
      // last word raises the interrupt and ends the load
      if (r.cnt == sbl_pkg::CNT_ONE) begin
        n.irq = r.dmac[sbl_pkg::DMAC_IRQ_EN];
        n.done = 1'b1;
        n.sel_n = 1'b1;
        n.sck = 1'b1;
        n.st = sbl_pkg::ST_DONE;
      end
    end
  end
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      // clock output high and select released from reset
      // dma parameters at their boot values
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end
  assign O_BOOT_SERIAL_CLOCK = r.sck;
  assign O_BOOT_SERIAL_CLOCK_OE = r.sck_oe;
  assign O_SERIAL_DATA_OUT = r.dout;
  assign O_SERIAL_DATA_OUT_OE = r.dout_oe;
  assign O_BOOT_MEMORY_SELECT_LINE_N = r.sel_n;
  assign O_MEM_WE = r.we;
  assign O_MEM_ADDR = r.addr;
  assign O_MEM_WDATA = r.wdata;
  assign O_RX_DONE_IRQ = r.irq;
  assign O_BOOT_DONE = r.done;
  assign O_BOOT_ABORT = r.abort;
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_master_start;
    r.st == sbl_pkg::ST_WAIT && s_rel && s_strap;
  endsequence
  sequence s_select_then_head;
    r.st == sbl_pkg::ST_M_SEL ##1 r.st == sbl_pkg::ST_M_HEAD && !r.sel_n;
  endsequence
  a_clock_idle_high: assert property (
    (r.st inside {sbl_pkg::ST_WAIT, sbl_pkg::ST_M_SEL, sbl_pkg::ST_DONE,
     sbl_pkg::ST_S_ARM}) |-> r.sck)
    else $error("serial clock not high while idle");
  a_select_before_clock: assert property (
    $fell(r.sck) |-> !r.sel_n && !$past(r.sel_n))
    else $error("clock toggled without memory select low");
  a_master_start_order: assert property (
    s_master_start |=> r.ctl == sbl_pkg::CTL_MASTER_BOOT ##0
    s_select_then_head)
    else $error("master start did not set control then select");
  a_header_bit_out: assert property (
    (r.st == sbl_pkg::ST_M_HEAD && $fell(r.sck)) |->
    r.dout == sbl_pkg::READ_HEADER[r.bitn])
    else $error("header bit on the wire is wrong");
  a_slave_control: assert property (
    $rose(r.st == sbl_pkg::ST_S_ARM) |-> r.ctl == sbl_pkg::CTL_SLAVE_BOOT
    && !r.dout_oe && !r.sck_oe)
    else $error("slave boot control value wrong");
  a_params_at_start: assert property (
    r.st == sbl_pkg::ST_WAIT |-> r.cnt == BOOT_COUNT &&
    r.dmac == sbl_pkg::DMAC_RESET && r.modi == sbl_pkg::MOD_RESET &&
    r.idx == VT_BASE)
    else $error("dma parameters not at boot values");
  a_baud_half_period: assert property (
    ($changed(r.sck) && $past(run)) |-> $past(r.div) == $past(half) -
    sbl_pkg::CNT_ONE)
    else $error("serial clock edge off the baud divisor");
  a_check_abort: assert property (
    (r.st == sbl_pkg::ST_M_VERIFY && !r.pk_vld &&
     lnk.shift[31:24] != sbl_pkg::CHECK_BYTE) |=>
    r.st == sbl_pkg::ST_ABORT && r.sel_n && r.abort)
    else $error("bad check byte did not abort");
  a_index_step: assert property (
    r.we |-> r.idx == r.addr + r.modi && $past(lnk.word_vld))
    else $error("memory write not at consecutive index");
  a_last_word_irq: assert property (
    (r.we && r.cnt == '0) |-> r.irq && r.done ##1 !r.we [*2])
    else $error("last word did not end the load");
  a_no_write_after_zero: assert property (
    (r.cnt == '0 && $past(r.cnt) == '0) |-> !r.we)
    else $error("memory write after count reached zero");
endmodule : sbl_top
`default_nettype wire

// File: core/sbl_pkg.sv
/*
  shared constants and types of the serial boot loader.
  assumes a 32-bit serial word and 32-bit internal memory words.
*/
`default_nettype none
package sbl_pkg;
  // ----------------------------------------------------------------------
  // register reset and boot values
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_MASTER_BOOT = 32'h0000_5d06;
  localparam logic [31:0] CTL_SLAVE_BOOT = 32'h0000_4d22;
  localparam logic [31:0] DMAC_RESET = 32'h0000_0007;
  localparam logic [31:0] MOD_RESET = 32'h0000_0001;
  localparam logic [31:0] CNT_RESET = 32'h0000_0180;
  localparam logic [31:0] BAUD_RESET = 32'h0000_0064;
  localparam logic [31:0] FLG_RESET = 32'h0000_fe01;
  localparam logic [31:0] VT_BASE_DEF = 32'h0009_0000;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTL_PORT_EN = 14;
  localparam int CTL_MASTER = 12;
  localparam int CTL_CPOL = 11;
  localparam int CTL_CPHA = 10;
  localparam int CTL_MSB_FIRST_BIT = 9;
  localparam int CTL_DOUT_DIS = 5;
  localparam int CTL_SEND_ZERO = 2;
  localparam int CTL_RX_DMA = 1;
  localparam int DMAC_EN = 0;
  localparam int DMAC_IRQ_EN = 2;
  localparam int FLG_SEL0 = 0;
  // ----------------------------------------------------------------------
  // link framing
  // ----------------------------------------------------------------------
  // read command then start address, stored so that lsb-first shifting
  // puts the command on the wire msb first
  localparam logic [23:0] READ_HEADER = 24'h00_00c0;
  localparam logic [4:0] HDR_LAST = 5'h17;
  localparam logic [4:0] CHK_LAST = 5'h07;
  localparam logic [4:0] WORD_LAST = 5'h1f;
  localparam logic [7:0] CHECK_BYTE = 8'ha5;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_WAIT, ST_M_SEL, ST_M_HEAD, ST_M_CHK, ST_M_VERIFY, ST_M_XFER,
    ST_S_ARM, ST_S_RUN, ST_DONE, ST_ABORT
  } sbl_state_t;
endpackage : sbl_pkg
`default_nettype wire

// File: core/sbl_shift_if.sv
/*
  bit stream into the receive shift register and words back out.
  assumes both ends run on the same clock.
*/
`default_nettype none
interface sbl_shift_if;
  logic bit_vld;
  logic bit_val;
  logic clr;
  logic word_vld;
  logic [31:0] shift;
  logic [31:0] word;
  modport core (output bit_vld, output bit_val, output clr,
                input word_vld, input shift, input word);
  modport packer (input bit_vld, input bit_val, input clr,
                  output word_vld, output shift, output word);
endinterface : sbl_shift_if
`default_nettype wire

// File: core/sbl_sync.sv
/*
  two flip-flop synchroniser for a group of independent levels.
  assumes each bit is a slow level or is sampled far from its edges.
*/
`default_nettype none
module sbl_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sbl_sync_st_t;
  sbl_sync_st_t st_r;
  sbl_sync_st_t st_nxt;

  if (W < 1) begin : g_chk
    $error("sbl_sync: width must be at least one");
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.s2;
endmodule : sbl_sync
`default_nettype wire

// File: core/sbl_pack.sv
/*
  32-bit receive shift register with lsb-first packing and word buffer.
  assumes the sender keeps bits coming without gaps between words.
*/
`default_nettype none
module sbl_pack (
  input wire logic i_clk,
  input wire logic i_rst_n,
  sbl_shift_if.packer lnk
);
  typedef struct packed {
    logic [31:0] shift;
    logic [4:0] cnt;
    logic [31:0] word;
    logic word_vld;
  } sbl_pack_st_t;
  sbl_pack_st_t r;
  sbl_pack_st_t n;

  always_comb begin
    n = r;
    n.word_vld = 1'b0;
    if (lnk.clr) begin
      n.shift = '0;
      n.cnt = '0;
    end else if (lnk.bit_vld) begin
      n.shift = {lnk.bit_val, r.shift[31:1]};
      n.cnt = r.cnt + 5'h1;
      if (r.cnt == sbl_pkg::WORD_LAST) begin
        n.word = {lnk.bit_val, r.shift[31:1]};
        n.word_vld = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lnk.shift = r.shift;
  assign lnk.word = r.word;
  assign lnk.word_vld = r.word_vld;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_word_full_count: assert property (
    lnk.word_vld |-> r.cnt == '0 && $past(lnk.bit_vld) && r.word == r.shift)
    else $error("word handed on before 32 bits were packed");
  a_word_fixed_size: assert property (
    (lnk.bit_vld && !lnk.clr && r.cnt != sbl_pkg::WORD_LAST) |=> !lnk.word_vld)
    else $error("word handed on at a count other than 32");
endmodule : sbl_pack
`default_nettype wire

// File: bench/sbl_flash_model.sv
/*
  serial flash model for master boot: captures the read header, then
  answers with a check byte and a repeating instruction-pair stream.
  assumes mode 3 timing and one frame per chip-select low period.
*/
`default_nettype none
module sbl_flash_model (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic [7:0] i_chk,
  output var logic o_miso,
  output var logic [23:0] o_hdr
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // stream contents
  // ----------------------------------------------------------------------
  // one instruction pair as three words
  localparam logic [31:0] PAT [3] = '{32'h3344_5566, 32'hccdd_1122,
                                      32'h7788_aabb};
  int n;
  initial o_miso = 1'b0;
  // ----------------------------------------------------------------------
  // link
  // ----------------------------------------------------------------------
  // header taken msb first on rising edges
  always @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      n <= 0;
    end else begin
      if (n < 24) begin
        o_hdr <= {o_hdr[22:0], i_mosi};
      end
      n <= n + 1;
    end
  end
  // check byte then words, lsb first, no gaps
  // a released line shows the inverse of its last level, so a design
  // that samples too early cannot get lucky
  always @(negedge i_sclk or posedge i_cs_n) begin
    if (!i_cs_n && n >= 24) begin
      o_miso <= (n < 32) ? i_chk[n-24] : PAT[((n-32)/32)%3][(n-32)%32];
    end else begin
      o_miso <= ~o_miso;
    end
  end
endmodule : sbl_flash_model
`default_nettype wire

// File: bench/sbl_top_tb.sv
/*
  self-checking bench of the serial boot loader: master abort, master
  start of load, full slave load.
  assumes the design top with its default vector base.
*/
`default_nettype none
module sbl_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] VT = sbl_pkg::VT_BASE_DEF;
  // a load shorter than the boot default keeps the run short
  localparam logic [31:0] NW = 32'h0000_0060;
  localparam logic [31:0] PAT [3] = '{32'h3344_5566, 32'hccdd_1122,
                                      32'h7788_aabb};
  logic clk, rst_n, rel, strap, hclk, sel_n, hdin, miso;
  logic sclk, sclk_oe, dout, dout_oe, msel_n, we, irq, done, abort;
  logic [31:0] addr, wdata;
  logic [23:0] hdr;
  logic [7:0] chkb;
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  int n_fail, cmp_count, nirq, irq_at;

  sbl_top #(.BOOT_COUNT(NW)) dut_u (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_CORE_RELEASE(rel),
    .I_BOOT_MASTER(strap), .I_BOOT_SERIAL_CLOCK(hclk),
    .I_SLAVE_SELECT_INPUT_N(sel_n),
    .I_SERIAL_DATA_IN(strap ? miso : hdin),
    .O_BOOT_SERIAL_CLOCK(sclk), .O_BOOT_SERIAL_CLOCK_OE(sclk_oe),
    .O_SERIAL_DATA_OUT(dout), .O_SERIAL_DATA_OUT_OE(dout_oe),
    .O_BOOT_MEMORY_SELECT_LINE_N(msel_n), .O_MEM_WE(we),
    .O_MEM_ADDR(addr), .O_MEM_WDATA(wdata), .O_RX_DONE_IRQ(irq),
    .O_BOOT_DONE(done), .O_BOOT_ABORT(abort)
  );
  sbl_flash_model flash_u (.i_sclk(sclk), .i_cs_n(msel_n), .i_mosi(dout),
    .i_chk(chkb), .o_miso(miso), .o_hdr(hdr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------------
  // write monitor
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (we === 1'b1) begin
      wa.push_back(addr);
      wd.push_back(wdata);
    end
    if (irq === 1'b1) begin
      nirq++;
      irq_at = wa.size();
    end
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task do_reset(input logic m);
    @(posedge clk);
    #1 rst_n = 1'b0;
    rel = 1'b0;
    strap = m;
    hclk = 1'b1;
    sel_n = 1'b1;
    wa.delete();
    wd.delete();
    nirq = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
  endtask : do_reset
  // host clock 80 ns; data changes with the falling edge (mode 3)
  task hsend(input logic [31:0] w);
    for (int b = 0; b < 32; b++) begin
      hclk = 1'b0;
      hdin = w[b];
      repeat (5) @(posedge clk);
      #1 hclk = 1'b1;
      repeat (5) @(posedge clk);
      #1;
    end
  endtask : hsend
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // bad check byte aborts the master load
  task t_m_abort;
    chkb = 8'h5a;
    do_reset(1'b1);
    repeat (10) @(posedge clk);
    chk("sclk_rst", sclk, 1);
    chk("sel_rst", msel_n, 1);
    chk("sclk_oe_rst", sclk_oe, 0);
    #1 rel = 1'b1;
    for (int i = 0; i < 20 && msel_n !== 1'b0; i++) @(posedge clk);
    #1;
    chk("sel_low", msel_n, 0);
    chk("sclk_first", sclk, 1);
    chk("sclk_oe", sclk_oe, 1);
    chk("dout_oe", dout_oe, 1);
    for (int i = 0; i < 4000 && abort !== 1'b1; i++) @(posedge clk);
    #1;
    chk("hdr", hdr, 24'h03_0000);
    chk("abort", abort, 1);
    chk("sel_abort", msel_n, 1);
    chk("sclk_abort", sclk, 1);
    chk("abort_wr", wa.size(), 0);
  endtask : t_m_abort
  // good check byte, first pair lands at the base
  task t_m_boot;
    chkb = 8'ha5;
    do_reset(1'b1);
    rel = 1'b1;
    for (int i = 0; i < 14000 && wa.size() < 3; i++) @(posedge clk);
    chk("abort_ok", abort, 0);
    for (int k = 0; k < 3; k++) begin
      chk("m_addr", wa[k], VT + k);
      chk("m_data", wd[k], PAT[k]);
    end
  endtask : t_m_boot
  // full slave load after a false start
  task t_slave;
    do_reset(1'b0);
    sel_n = 1'b0;
    rel = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    hsend(PAT[0]);
    hsend(PAT[1]);
    repeat (10) @(posedge clk);
    chk("no_start", wa.size(), 0);
    chk("s_sclk_oe", sclk_oe, 0);
    chk("s_dout_oe", dout_oe, 0);
    #1 sel_n = 1'b1;
    hdin = ~hdin;
    repeat (10) @(posedge clk);
    #1 sel_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    // a word host sends each pattern word as one lsb-first stream
    for (int k = 0; k < NW; k++) hsend(PAT[k % 3]);
    repeat (10) @(posedge clk);
    chk("count", wa.size(), NW);
    chk("irq_cnt", nirq, 1);
    chk("irq_at", irq_at, NW);
    chk("done", done, 1);
    for (int k = 0; k < NW; k++) begin
      chk("s_addr", wa[k], VT + k);
      chk("s_data", wd[k], PAT[k % 3]);
    end
    hsend(PAT[0]);
    repeat (10) @(posedge clk);
    chk("stop", wa.size(), NW);
  endtask : t_slave
  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    rel = 1'b0;
    strap = 1'b0;
    hclk = 1'b1;
    sel_n = 1'b1;
    hdin = 1'b0;
    chkb = 8'h00;
    n_fail = 0;
    cmp_count = 0;
    nirq = 0;
    irq_at = 0;
    t_m_abort;
    t_m_boot;
    t_slave;
    test_done;
  end
  // full run is about 48k cycles; the limit leaves margin for a slow load
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    test_done;
  end
endmodule : sbl_top_tb
`default_nettype wire
